// ### core/evt_params.svh
// Purpose: Constants for the endian and virtualisation trap control block
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes:   Included by every design module
//
// Overview of operation
// - Instruction fetches are always little-endian
// - Machine-mode data order follows machine bit
// - Supervisor bit zero without supervisor; selects order
// - User bit zero without user; selects order
// - Page-table walks use the supervisor order bit
// - Tied order bits ignore writes
// - Little-only ties zero; big-only ties one
// - Byte order never changes addresses
// - Trap supervisor translation register and fence
// - Translation trap bit zero without supervisor
// - Wait instruction allowed when wait trap clear
// - Wait trap set: bounded lower-mode wait, then illegal
// - Wait trap bit zero with machine only
// - User wait bounded when supervisor exists
// - Trap supervisor return when return trap set
// - Return trap bit zero without supervisor
// - Modify flag uses previous privilege for data
`ifndef EVT_PARAMS_SVH
`define EVT_PARAMS_SVH

// ************************************************
// Bus map
// ************************************************
`define AXI_AW         8
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ************************************************
// Field positions
// ************************************************
`define BIT_M_ORDER    0
`define BIT_S_ORDER    1
`define BIT_U_ORDER    2
`define BIT_PRIV_MOD   3
`define BIT_PREV_LO    4
`define BIT_PREV_HI    5
`define BIT_VM_TRAP    6
`define BIT_WAIT_TRAP  7
`define BIT_SRTN_TRAP  8
`define ST_PRIV_LO     0
`define ST_PRIV_HI     1
`define ST_DATA_BE     2
`define ST_WAITING     3
`define ST_CNT_LO      8
`define ST_CNT_HI      15

// ************************************************
// Encodings and reset values
// ************************************************
`define PRIV_U         2'h0
`define PRIV_S         2'h1
`define PRIV_M         2'h3
`define ORDER_BI       2'h0
`define ORDER_LITTLE   2'h1
`define ORDER_BIG      2'h2
`define TIE_NONE       2'h0
`define TIE_M          2'h1
`define TIE_S          2'h2
`define SIZE_BYTE      2'h0
`define SIZE_HALF      2'h1
`define CTRL_BIT_RST   1'b0

// ************************************************
// Timing
// ************************************************
`define CLK_PERIOD_NS  50
`define WAIT_LIMIT_NS  800
`define WAIT_LIMIT_CYC (`WAIT_LIMIT_NS / `CLK_PERIOD_NS)

`endif

// ### core/evt_pkg.sv
// Purpose: Types for the endian and virtualisation trap control block
// Assumes: Nothing
// Notes:   Constants live in evt_params.svh
package evt_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_XLAT_REG, OP_XLAT_FENCE, OP_WAIT_INT,
                             OP_SUP_RETURN} evt_op_e;
   typedef enum logic {WS_IDLE, WS_WAIT} evt_wait_e;
   typedef logic [1:0] evt_priv_t;
endpackage

// ### core/evt_lane_swap.sv
// Purpose: Byte lane reversal within the access size
// Assumes: Size 0 byte, 1 halfword, otherwise word
// Notes:   Purely combinational
`timescale 1ns/1ns
`include "evt_params.svh"
module evt_lane_swap (
   input  logic        swap,
   input  logic [1:0]  size,
   input  logic [31:0] din,
   output logic [31:0] dout
);
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_lane
         logic [1:0] src;
         always_comb begin
            if (!swap || size == `SIZE_BYTE) begin
               src = 2'(i);
            end else if (size == `SIZE_HALF) begin
               src = 2'(i) ^ 2'h1;
            end else begin
               src = 2'h3 - 2'(i);
            end
         end
         assign dout[8*i +: 8] = din[8*src +: 8];
      end
   endgenerate
endmodule // evt_lane_swap

// ### core/evt_wait_timer.sv
// Purpose: Bounded wait limit for the wait-for-interrupt instruction
// Assumes: start and stop are one-cycle requests
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ns
`include "evt_params.svh"
module evt_wait_timer (
   input  logic aclk,
   input  logic aresetn,
   input  logic ce,
   input  logic start,
   input  logic stop,
   output logic expired
);
   logic [7:0] left_r;
   logic       active_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_r <= 1'b0;
         left_r   <= 8'h00;
         expired  <= 1'b0;
      end else if (ce) begin
         expired <= 1'b0;
         if (stop) begin
            active_r <= 1'b0;
         end else if (start) begin
            active_r <= 1'b1;
            left_r   <= 8'(`WAIT_LIMIT_CYC);
         end else if (active_r) begin
            if (left_r == 8'h01) begin
               active_r <= 1'b0;
               expired  <= 1'b1;
            end
            left_r <= left_r - 8'h01;
         end
      end
   end
endmodule // evt_wait_timer

// ### core/evt_ctrl.sv
// Purpose: Data byte order and virtualisation trap controls of a hart
// Assumes: Hart inputs synchronous to aclk; op_valid one cycle per op
// Notes:   Registers reached over AXI4-Lite
`timescale 1ns/1ns
`include "evt_params.svh"
module evt_ctrl #(
   parameter bit         HAS_S          = 1'b1,
   parameter bit         HAS_U          = 1'b1,
   parameter logic [1:0] ORDER_SUPPORT  = `ORDER_BI,
   parameter logic [1:0] S_ORDER_TIE    = `TIE_NONE,
   parameter logic [1:0] U_ORDER_TIE    = `TIE_NONE
) (
   input  logic                  aclk,
   input  logic                  aresetn,
   input  logic                  ce,
   input  logic [`AXI_AW-1:0]    s_axi_awaddr,
   input  logic                  s_axi_awvalid,
   output logic                  s_axi_awready,
   input  logic [31:0]           s_axi_wdata,
   input  logic [3:0]            s_axi_wstrb,
   input  logic                  s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  logic                  s_axi_bready,
   input  logic [`AXI_AW-1:0]    s_axi_araddr,
   input  logic                  s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  logic                  s_axi_rready,
   input  evt_pkg::evt_priv_t    cur_priv,
   input  logic                  op_valid,
   input  evt_pkg::evt_op_e      op_kind,
   input  logic                  wait_done,
   input  logic                  ls_valid,
   input  logic [1:0]            ls_size,
   input  logic [31:0]           ls_addr,
   input  logic [31:0]           ld_data,
   input  logic [31:0]           st_data,
   output logic                  fetch_big_endian,
   output logic                  data_big_endian,
   output logic                  walk_big_endian,
   output evt_pkg::evt_priv_t    ls_priv,
   output logic                  ls_valid_q,
   output logic [31:0]           ls_addr_q,
   output logic [31:0]           ld_data_q,
   output logic [31:0]           st_data_q,
   output logic                  illegal_instr,
   output logic                  wait_pending
);
   // ************************************************
   // Control fields
   // ************************************************
   logic                 machine_data_byte_order_r;
   logic                 supervisor_data_byte_order_r;
   logic                 user_data_byte_order_r;
   logic                 privilege_modify_flag_r;
   evt_pkg::evt_priv_t   machine_previous_privilege_r;
   logic                 trap_virtual_memory_ops_r;
   logic                 wait_timeout_trap_r;
   logic                 supervisor_return_trap_r;
   logic                 m_order;
   logic                 s_order;
   logic                 u_order;
   logic                 priv_mod;
   logic                 vm_trap;
   logic                 wt_trap;
   logic                 srtn_trap;
   evt_pkg::evt_priv_t   eff_priv;
   logic                 data_be;
   logic [7:0]           illegal_cnt_r;

   // Legal values seen by logic and by reads
   always_comb begin
      if (ORDER_SUPPORT == `ORDER_LITTLE) begin
         m_order = 1'b0;
         s_order = 1'b0;
         u_order = 1'b0;
      end else if (ORDER_SUPPORT == `ORDER_BIG) begin
         m_order = 1'b1;
         s_order = HAS_S;
         u_order = HAS_U;
      end else begin
         m_order = machine_data_byte_order_r;
         s_order = HAS_S && ((S_ORDER_TIE == `TIE_M) ? m_order
                                                     : supervisor_data_byte_order_r);
         if (!HAS_U) begin
            u_order = 1'b0;
         end else if (U_ORDER_TIE == `TIE_M) begin
            u_order = m_order;
         end else if (U_ORDER_TIE == `TIE_S) begin
            u_order = s_order;
         end else begin
            u_order = user_data_byte_order_r;
         end
      end
   end

   assign priv_mod  = HAS_U && privilege_modify_flag_r;
   assign vm_trap   = HAS_S && trap_virtual_memory_ops_r;
   assign wt_trap   = (HAS_S || HAS_U) && wait_timeout_trap_r;
   assign srtn_trap = HAS_S && supervisor_return_trap_r;

   function automatic logic prev_ok(input logic [1:0] v);
      prev_ok = (v == `PRIV_M) || (v == `PRIV_S && HAS_S) || (v == `PRIV_U && HAS_U);
   endfunction

   // ************************************************
   // AXI4-Lite slave
   // ************************************************
   logic [`AXI_AW-1:0] awaddr_q;
   logic [31:0]        wdata_q;
   logic [3:0]         wstrb_q;
   logic               aw_got_r;
   logic               w_got_r;
   logic               aw_got_nxt;
   logic               w_got_nxt;
   logic               wr_do;
   logic [31:0]        ctrl_rd;
   logic [31:0]        stat_rd;
   evt_pkg::evt_wait_e wait_st_r;
   evt_pkg::evt_wait_e wait_st_nxt;

   assign wr_do      = aw_got_r && w_got_r && !s_axi_bvalid;
   assign aw_got_nxt = wr_do ? 1'b0 : ((s_axi_awvalid && s_axi_awready) || aw_got_r);
   assign w_got_nxt  = wr_do ? 1'b0 : ((s_axi_wvalid && s_axi_wready) || w_got_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end else if (ce) begin
         aw_got_r      <= aw_got_nxt;
         w_got_r       <= w_got_nxt;
         s_axi_awready <= !aw_got_nxt;
         s_axi_wready  <= !w_got_nxt;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == `REG_CTRL || awaddr_q == `REG_STATUS) ? `RESP_OKAY
                                                                             : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register writes; mode bits keep old value when illegal
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         machine_data_byte_order_r    <= `CTRL_BIT_RST;
         supervisor_data_byte_order_r <= `CTRL_BIT_RST;
         user_data_byte_order_r       <= `CTRL_BIT_RST;
         privilege_modify_flag_r      <= `CTRL_BIT_RST;
         machine_previous_privilege_r <= HAS_U ? `PRIV_U : `PRIV_M;
         trap_virtual_memory_ops_r    <= `CTRL_BIT_RST;
         wait_timeout_trap_r          <= `CTRL_BIT_RST;
         supervisor_return_trap_r     <= `CTRL_BIT_RST;
      end else if (ce && wr_do && awaddr_q == `REG_CTRL) begin
         if (wstrb_q[0]) begin
            machine_data_byte_order_r    <= wdata_q[`BIT_M_ORDER];
            supervisor_data_byte_order_r <= wdata_q[`BIT_S_ORDER];
            user_data_byte_order_r       <= wdata_q[`BIT_U_ORDER];
            privilege_modify_flag_r      <= wdata_q[`BIT_PRIV_MOD];
            trap_virtual_memory_ops_r    <= wdata_q[`BIT_VM_TRAP];
            wait_timeout_trap_r          <= wdata_q[`BIT_WAIT_TRAP];
            if (prev_ok(wdata_q[`BIT_PREV_HI:`BIT_PREV_LO])) begin
               machine_previous_privilege_r <= wdata_q[`BIT_PREV_HI:`BIT_PREV_LO];
            end
         end
         if (wstrb_q[1]) begin
            supervisor_return_trap_r <= wdata_q[`BIT_SRTN_TRAP];
         end
      end
   end

   // Read data always show the legal field values
   always_comb begin
      ctrl_rd                             = 32'h0000_0000;
      ctrl_rd[`BIT_M_ORDER]               = m_order;
      ctrl_rd[`BIT_S_ORDER]               = s_order;
      ctrl_rd[`BIT_U_ORDER]               = u_order;
      ctrl_rd[`BIT_PRIV_MOD]              = priv_mod;
      ctrl_rd[`BIT_PREV_HI:`BIT_PREV_LO]  = machine_previous_privilege_r;
      ctrl_rd[`BIT_VM_TRAP]               = vm_trap;
      ctrl_rd[`BIT_WAIT_TRAP]             = wt_trap;
      ctrl_rd[`BIT_SRTN_TRAP]             = srtn_trap;
      stat_rd                             = 32'h0000_0000;
      stat_rd[`ST_PRIV_HI:`ST_PRIV_LO]    = eff_priv;
      stat_rd[`ST_DATA_BE]                = data_be;
      stat_rd[`ST_WAITING]                = (wait_st_r == evt_pkg::WS_WAIT);
      stat_rd[`ST_CNT_HI:`ST_CNT_LO]      = illegal_cnt_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            if (s_axi_araddr == `REG_CTRL) begin
               s_axi_rdata <= ctrl_rd;
            end else if (s_axi_araddr == `REG_STATUS) begin
               s_axi_rdata <= stat_rd;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ************************************************
   // Data byte order and load-store path
   // ************************************************
   logic [31:0] ld_swapped;
   logic [31:0] st_swapped;

   assign eff_priv = priv_mod ? machine_previous_privilege_r : cur_priv;

   always_comb begin
      if (eff_priv == `PRIV_M) begin
         data_be = m_order;
      end else if (eff_priv == `PRIV_S) begin
         data_be = s_order;
      end else begin
         data_be = u_order;
      end
   end

   evt_lane_swap u_ld_swap (
      .swap (data_be),
      .size (ls_size),
      .din  (ld_data),
      .dout (ld_swapped)
   );

   evt_lane_swap u_st_swap (
      .swap (data_be),
      .size (ls_size),
      .din  (st_data),
      .dout (st_swapped)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fetch_big_endian <= 1'b0;
         data_big_endian  <= 1'b0;
         walk_big_endian  <= 1'b0;
         ls_priv          <= `PRIV_M;
         ls_valid_q       <= 1'b0;
         ls_addr_q        <= 32'h0000_0000;
         ld_data_q        <= 32'h0000_0000;
         st_data_q        <= 32'h0000_0000;
      end else if (ce) begin
         fetch_big_endian <= 1'b0;
         data_big_endian  <= data_be;
         walk_big_endian  <= s_order;
         ls_priv          <= eff_priv;
         ls_valid_q       <= ls_valid;
         ls_addr_q        <= ls_addr;
         ld_data_q        <= ld_swapped;
         st_data_q        <= st_swapped;
      end
   end

   // ************************************************
   // Trap decisions
   // ************************************************
   logic wait_bound;
   logic wait_start;
   logic expired;
   logic trap_now;

   // Lower-mode wait bounded when wait trap set; user wait also when supervisor exists
   assign wait_bound = (cur_priv != `PRIV_M) &&
                       (wt_trap || (HAS_S && cur_priv == `PRIV_U));
   assign wait_start = op_valid && op_kind == evt_pkg::OP_WAIT_INT && wait_bound &&
                       wait_st_r == evt_pkg::WS_IDLE;

   always_comb begin
      wait_st_nxt = wait_st_r;
      case (wait_st_r)
         evt_pkg::WS_IDLE: begin
            if (wait_start) begin
               wait_st_nxt = evt_pkg::WS_WAIT;
            end
         end
         evt_pkg::WS_WAIT: begin
            if (wait_done || expired) begin
               wait_st_nxt = evt_pkg::WS_IDLE;
            end
         end
         default: wait_st_nxt = evt_pkg::WS_IDLE;
      endcase
   end

   evt_wait_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .start   (wait_start),
      .stop    (wait_done),
      .expired (expired)
   );

   always_comb begin
      trap_now = 1'b0;
      if (op_valid && cur_priv == `PRIV_S) begin
         if ((op_kind == evt_pkg::OP_XLAT_REG || op_kind == evt_pkg::OP_XLAT_FENCE) &&
             vm_trap) begin
            trap_now = 1'b1;
         end
         if (op_kind == evt_pkg::OP_SUP_RETURN && srtn_trap) begin
            trap_now = 1'b1;
         end
      end
      if (wait_st_r == evt_pkg::WS_WAIT && expired && !wait_done) begin
         trap_now = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_st_r     <= evt_pkg::WS_IDLE;
         wait_pending  <= 1'b0;
         illegal_instr <= 1'b0;
         illegal_cnt_r <= 8'h00;
      end else if (ce) begin
         wait_st_r     <= wait_st_nxt;
         wait_pending  <= (wait_st_nxt == evt_pkg::WS_WAIT);
         illegal_instr <= trap_now;
         if (trap_now) begin
            illegal_cnt_r <= illegal_cnt_r + 8'h01;
         end
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   localparam int WAIT_MAX = `WAIT_LIMIT_CYC + 1;
   logic [7:0] wait_cyc;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_cyc <= 8'h00;
      end else if (ce) begin
         wait_cyc <= (wait_st_nxt == evt_pkg::WS_WAIT) ? wait_cyc + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_xlat_op;
      ce && op_valid && cur_priv == `PRIV_S &&
      (op_kind == evt_pkg::OP_XLAT_REG || op_kind == evt_pkg::OP_XLAT_FENCE);
   endsequence
   sequence s_sup_ret;
      ce && op_valid && cur_priv == `PRIV_S && op_kind == evt_pkg::OP_SUP_RETURN;
   endsequence

   property p_fetch_le;
      !fetch_big_endian;
   endproperty
   a_fetch_le: assert property (p_fetch_le) else $error("fetch not little-endian");
   property p_m_order;
      ce && eff_priv == `PRIV_M |=> data_big_endian == $past(m_order);
   endproperty
   a_m_order: assert property (p_m_order) else $error("machine order wrong");
   property p_s_absent;
      !HAS_S |-> !s_order && !vm_trap && !srtn_trap;
   endproperty
   a_s_absent: assert property (p_s_absent) else $error("supervisor bit not zero");
   property p_u_absent;
      !HAS_U |-> !u_order && !priv_mod;
   endproperty
   a_u_absent: assert property (p_u_absent) else $error("user bit not zero");
   property p_walk;
      ce |=> walk_big_endian == $past(s_order);
   endproperty
   a_walk: assert property (p_walk) else $error("walk order wrong");
   property p_tied;
      S_ORDER_TIE == `TIE_M && ORDER_SUPPORT == `ORDER_BI && HAS_S |-> s_order == m_order;
   endproperty
   a_tied: assert property (p_tied) else $error("tied bit diverged");
   property p_xlat_trap;
      s_xlat_op ##0 vm_trap |=> illegal_instr;
   endproperty
   a_xlat_trap: assert property (p_xlat_trap) else $error("translation op not trapped");
   property p_supervisor_trap_return_trap;
      s_sup_ret ##0 wait_st_r == evt_pkg::WS_IDLE |=> illegal_instr == $past(srtn_trap);
   endproperty
   a_supervisor_trap_return_trap: assert property (p_supervisor_trap_return_trap) else $error("return trap wrong");
   property p_wait_bound;
      wait_st_r == evt_pkg::WS_WAIT |-> wait_cyc <= WAIT_MAX;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("wait exceeds bound");
   property p_user_wait;
      ce && op_valid && op_kind == evt_pkg::OP_WAIT_INT && cur_priv == `PRIV_U && HAS_S &&
      wait_st_r == evt_pkg::WS_IDLE |=> wait_pending ##0 wait_st_r == evt_pkg::WS_WAIT;
   endproperty
   a_user_wait: assert property (p_user_wait) else $error("user wait not bounded");
   property p_addr_keep;
      ce |=> ls_addr_q == $past(ls_addr);
   endproperty
   a_addr_keep: assert property (p_addr_keep) else $error("address altered");
   property p_lane_word;
      ce && data_be && ls_size == 2'h2 |=>
         ld_data_q == {$past(ld_data[7:0]), $past(ld_data[15:8]),
                       $past(ld_data[23:16]), $past(ld_data[31:24])};
   endproperty
   a_lane_word: assert property (p_lane_word) else $error("word lanes not reversed");
endmodule // evt_ctrl

// ### bench/evt_ctrl_tb_top.sv
// Purpose: Self-checking bench for evt_ctrl
// Assumes: Default parameters, ce held high
// Notes:   AXI4-Lite tasks plus hart op and load/store drivers
`timescale 1ns/1ns
`include "evt_params.svh"
module evt_ctrl_tb_top;
   logic aclk, aresetn, ce, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
   logic op_valid, wait_done, ls_valid, fbe, dbe, wbe, lsv_q, illegal_instr, wait_pending;
   logic [`AXI_AW-1:0] awa, ara;
   logic [31:0] wd, rd, ls_addr, ld_data, st_data, la_q, ld_q, st_q, v;
   logic [1:0] bresp, rresp, ls_size;
   logic [1:0] sz = 2'h2;
   logic [3:0] wstrb;
   evt_pkg::evt_priv_t cur_priv, ls_priv;
   evt_pkg::evt_op_e op_kind;
   int error_cnt = 0, total_checks = 0, cyc = 0, n;
   evt_ctrl uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .cur_priv(cur_priv), .op_valid(op_valid), .op_kind(op_kind), .wait_done(wait_done),
      .ls_valid(ls_valid), .ls_size(ls_size), .ls_addr(ls_addr), .ld_data(ld_data),
      .st_data(st_data), .fetch_big_endian(fbe), .data_big_endian(dbe),
      .walk_big_endian(wbe), .ls_priv(ls_priv), .ls_valid_q(lsv_q), .ls_addr_q(la_q),
      .ld_data_q(ld_q), .st_data_q(st_q), .illegal_instr(illegal_instr),
      .wait_pending(wait_pending));
   // ************************************************
   // Tasks
   // ************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (!bv);
      br <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, r});
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      d = rd;
      rr <= 1'b0;
      chk("rresp", {30'h0, rresp}, {30'h0, r});
   endtask
   task automatic op(input evt_pkg::evt_priv_t p, input evt_pkg::evt_op_e k, input logic e);
      cur_priv <= p; op_kind <= k; op_valid <= 1'b1;
      @(posedge aclk);
      op_valid <= 1'b0;
      @(posedge aclk);
      chk("illegal", {31'h0, illegal_instr}, {31'h0, e});
   endtask
   task automatic ld(input evt_pkg::evt_priv_t p, input logic e, input logic [31:0] x);
      cur_priv <= p; ls_valid <= 1'b1; ls_size <= sz; ld_data <= 32'h11223344;
      st_data <= 32'h11223344;
      @(posedge aclk);
      ls_valid <= 1'b0;
      @(posedge aclk);
      chk("data_be", {31'h0, dbe}, {31'h0, e});
      chk("ld_q", ld_q, x);
      chk("st_q", st_q, x);
      chk("lsv_q", {31'h0, lsv_q}, 32'h1);
      chk("addr_q", la_q, 32'h00000104);
   endtask
   // ************************************************
   // Stimulus
   // ************************************************
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         stop_test;
      end
   end
   initial begin
      {aresetn, awv, wv, br, arv, rr, op_valid, wait_done, ls_valid} = '0;
      ce = 1'b1; wstrb = 4'hF; awa = '0; ara = '0; wd = '0; cur_priv = `PRIV_M;
      op_kind = evt_pkg::OP_NONE; ls_size = '0; ls_addr = 32'h104; ld_data = '0; st_data = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(`REG_CTRL, v, `RESP_OKAY); chk("ctrl_rst", v, 32'h0);
      ld(`PRIV_M, 1'b0, 32'h11223344);
      axw(`REG_CTRL, 32'h00000001, `RESP_OKAY);
      ld(`PRIV_M, 1'b1, 32'h44332211);
      chk("fetch_be", {31'h0, fbe}, 32'h0);
      ld(`PRIV_S, 1'b0, 32'h11223344);
      axw(`REG_CTRL, 32'h00000006, `RESP_OKAY);
      op(`PRIV_M, evt_pkg::OP_XLAT_FENCE, 1'b0);
      ld(`PRIV_S, 1'b1, 32'h44332211);
      ld(`PRIV_U, 1'b1, 32'h44332211);
      sz = 2'h1;
      ld(`PRIV_S, 1'b1, 32'h22114433);
      sz = 2'h0;
      ld(`PRIV_S, 1'b1, 32'h11223344);
      sz = 2'h2;
      chk("walk_be", {31'h0, wbe}, 32'h1);
      axw(`REG_CTRL, 32'h0000001A, `RESP_OKAY);
      ld(`PRIV_M, 1'b1, 32'h44332211);
      chk("ls_priv", {30'h0, ls_priv}, 32'h1);
      axr(`REG_CTRL, v, `RESP_OKAY); chk("ctrl_rb", v, 32'h0000001A);
      op(`PRIV_S, evt_pkg::OP_XLAT_FENCE, 1'b0);
      op(`PRIV_S, evt_pkg::OP_SUP_RETURN, 1'b0);
      axw(`REG_CTRL, 32'h000001C0, `RESP_OKAY);
      op(`PRIV_S, evt_pkg::OP_XLAT_FENCE, 1'b1);
      op(`PRIV_S, evt_pkg::OP_XLAT_REG, 1'b1);
      op(`PRIV_S, evt_pkg::OP_SUP_RETURN, 1'b1);
      op(`PRIV_M, evt_pkg::OP_SUP_RETURN, 1'b0);
      op(`PRIV_S, evt_pkg::OP_WAIT_INT, 1'b0);
      chk("pending", {31'h0, wait_pending}, 32'h1);
      n = 1;
      while (!illegal_instr && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk("wait_cyc", n, 32'd18);
      op(`PRIV_S, evt_pkg::OP_WAIT_INT, 1'b0);
      wait_done <= 1'b1;
      repeat (2) @(posedge aclk);
      wait_done <= 1'b0;
      chk("done", {31'h0, wait_pending | illegal_instr}, 32'h0);
      axw(`REG_CTRL, 32'h00000000, `RESP_OKAY);
      op(`PRIV_S, evt_pkg::OP_WAIT_INT, 1'b0);
      chk("s_wait", {31'h0, wait_pending}, 32'h0);
      op(`PRIV_U, evt_pkg::OP_WAIT_INT, 1'b0);
      chk("u_wait", {31'h0, wait_pending}, 32'h1);
      repeat (20) @(posedge aclk);
      axw(`REG_STATUS, 32'hFFFFFFFF, `RESP_OKAY);
      axw(8'h10, 32'h00000001, `RESP_SLVERR);
      axr(`REG_STATUS, v, `RESP_OKAY); chk("status", v, 32'h00000500);
      axr(8'h10, v, `RESP_SLVERR); chk("unmapped", v, 32'h0);
      stop_test;
   end
endmodule // evt_ctrl_tb_top
